// file: radio_control_register_bank.sv
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "radio_regs_defines.svh"

//
// Overview of operation
// R01 - control byte at 07 resets to 01h, only oscillator enable set
// R02 - control byte at 08 resets to 00h; antenna select bits 7:5, flags below
// R03 - byte 14 holds 5-bit wake exponent, resets to 03h
// R04 - 16-bit wake mantissa: high byte 15 resets 00h, low byte 16 resets 01h
// R05 - wake count readable at 17 (high) and 18 (low), read only
// R06 - low duty on-duration at 19, read/write, resets to 00h
// R07 - battery threshold bits 4:0 at 1A, upper bits reserved, resets 14h
// R08 - amplifier offset bits 3:0 at 10, upper bits reserved, resets 00h
// R09 - reserved and constant-zero bits read zero and ignore writes
// R10 - host treats status and value registers as read-only, undefined at reset
module radio_control_register_bank #(
	parameter logic [4:0] TYPE_CODE = 5'h0a,  // arbitrary value
	parameter logic [4:0] REV_CODE  = 5'h01   // arbitrary value
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic                             irq,
	input  wire radio_regs_pkg::radio_status_t status,
	output radio_regs_pkg::radio_cfg_t        cfg
);
	import radio_regs_pkg::*;

	apb_phase_t  phase_ff;
	apb_phase_t  nxt_phase;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        irq_ff;
	logic        nxt_irq;
	logic        swres_ff;
	logic [7:0]  regs_ff [0:`REG_COUNT-1];
	logic [7:0]  flags_ff [0:1];
	logic [7:0]  nxt_flags [0:1];
	logic [7:0]  events [0:1];
	logic [7:0]  clr_bits [0:1];
	logic [4:0]  idx;
	logic        mapped;
	logic        setup;
	logic        access_done;
	logic        wr_en;
	logic [7:0]  wr_byte;
	logic [7:0]  rd_byte;
	logic [15:0] wake_count;
	logic        wake_expired;
	logic        wake_enable;

	function automatic logic reg_is_rw(input logic [4:0] i);
		unique case (i)
			`REG_IDX_MASK1, `REG_IDX_MASK2, `REG_IDX_OPCTL1,
			`REG_IDX_OPCTL2, `REG_IDX_XTAL, `REG_IDX_CLKOUT,
			`REG_IDX_PIN0, `REG_IDX_PIN1, `REG_IDX_PIN2,
			`REG_IDX_IOPORT, `REG_IDX_ADCSET, `REG_IDX_ADCOFFS,
			`REG_IDX_TSCTL, `REG_IDX_TVOFFS, `REG_IDX_WTEXP,
			`REG_IDX_WTMHI, `REG_IDX_WTMLO, `REG_IDX_LDC,
			`REG_IDX_LBDT: reg_is_rw = 1'b1;
			default:       reg_is_rw = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] reg_reset(input logic [4:0] i);
		unique case (i)
			`REG_IDX_MASK1:  reg_reset = `RST_MASK1;
			`REG_IDX_MASK2:  reg_reset = `RST_MASK2;
			`REG_IDX_OPCTL1: reg_reset = `RST_OPCTL1;  // R01
			`REG_IDX_OPCTL2: reg_reset = `RST_OPCTL2;  // R02
			`REG_IDX_XTAL:   reg_reset = `RST_XTAL;
			`REG_IDX_CLKOUT: reg_reset = `RST_CLKOUT;
			`REG_IDX_TSCTL:  reg_reset = `RST_TSCTL;
			`REG_IDX_WTEXP:  reg_reset = `RST_WTEXP;   // R03
			`REG_IDX_WTMHI:  reg_reset = `RST_WTMHI;   // R04
			`REG_IDX_WTMLO:  reg_reset = `RST_WTMLO;   // R04
			`REG_IDX_LDC:    reg_reset = `RST_LDC;     // R06
			`REG_IDX_LBDT:   reg_reset = `RST_LBDT;    // R07
			default:         reg_reset = `RST_ZERO;    // R08
		endcase
	endfunction

	// reserved bits are never stored, so they cannot read back nonzero
	function automatic logic [7:0] reg_wmask(input logic [4:0] i);
		unique case (i)
			`REG_IDX_OPCTL1:  reg_wmask = `WMASK_OPCTL1;   // R09
			`REG_IDX_CLKOUT:  reg_wmask = `WMASK_CLKOUT;   // R09
			`REG_IDX_IOPORT:  reg_wmask = `WMASK_IOPORT;   // R09
			`REG_IDX_ADCOFFS: reg_wmask = `WMASK_ADCOFFS;  // R08
			`REG_IDX_WTEXP:   reg_wmask = `WMASK_WTEXP;    // R03
			`REG_IDX_LBDT:    reg_wmask = `WMASK_LBDT;     // R07
			default:          reg_wmask = `WMASK_FULL;
		endcase
	endfunction

	// bus decode: each byte register takes one aligned word
	assign idx    = paddr[`PADDR_IDX_HI:`PADDR_IDX_LO];
	assign mapped = !paddr[`PADDR_TOP] && (idx <= `REG_IDX_LAST);
	assign setup  = psel && !penable;
	assign access_done = (phase_ff == PH_ACCESS) && psel && penable &&
		pready_ff;
	assign wr_en   = access_done && pwrite && mapped && reg_is_rw(idx);
	assign wr_byte = pwdata[7:0];

	// read mux; status values are live, so software sees no reset value
	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			`REG_IDX_TYPE:   rd_byte = {3'b000, TYPE_CODE};
			`REG_IDX_REV:    rd_byte = {3'b000, REV_CODE};
			`REG_IDX_STATE:  rd_byte = status.dev_state & `RMASK_STATE; // R09
			`REG_IDX_FLAGS1: rd_byte = flags_ff[0];
			`REG_IDX_FLAGS2: rd_byte = flags_ff[1];
			`REG_IDX_ADCVAL: rd_byte = status.adc_value;           // R10
			`REG_IDX_WTVHI:  rd_byte = wake_count[15:8];           // R05
			`REG_IDX_WTVLO:  rd_byte = wake_count[7:0];            // R05
			`REG_IDX_VBAT:   rd_byte = {3'b000, status.battery_level}; // R09
			default:         rd_byte = mapped ? regs_ff[idx] : 8'h00;
		endcase
	end

	assign nxt_prdata = (setup && !pwrite) ? {24'h000000, rd_byte} :
		32'h0000_0000;

	always_comb begin
		nxt_phase = phase_ff;
		unique case (phase_ff)
			PH_IDLE: begin
				if (setup) begin
					nxt_phase = PH_ACCESS;
				end
			end
			PH_ACCESS: begin
				if (access_done || !psel) begin
					nxt_phase = PH_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_ff   <= PH_IDLE;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			phase_ff   <= nxt_phase;
			pready_ff  <= setup;
			pslverr_ff <= setup && !mapped;
			prdata_ff  <= nxt_prdata;
		end
	end

	// a software reset written to the first control byte restores the bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swres_ff <= 1'b0;
		end else begin
			swres_ff <= wr_en && (idx == `REG_IDX_OPCTL1) &&
				wr_byte[`BIT_SWRES];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `REG_COUNT; gi = gi + 1) begin : g_reg
			if (reg_is_rw(5'(gi))) begin : g_rw
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						regs_ff[gi] <= reg_reset(5'(gi));  // R01
					end else if (swres_ff) begin
						regs_ff[gi] <= reg_reset(5'(gi));
					end else if (wr_en && idx == 5'(gi)) begin
						regs_ff[gi] <= wr_byte & reg_wmask(5'(gi)); // R09
					end
				end
			end else begin : g_ro
				assign regs_ff[gi] = 8'h00;
			end
		end
	endgenerate

	// sticky event flags, write one to clear; a new event beats the clear
	assign events[0] = status.events_first;
	assign events[1] = status.events_second |
		({7'h00, wake_expired} << `BIT_IWUT);

	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
			assign clr_bits[gi] = (access_done && pwrite && mapped &&
				idx == 5'(`REG_IDX_FLAGS1 + gi)) ? wr_byte : 8'h00;
			assign nxt_flags[gi] = swres_ff ? events[gi] :
				((flags_ff[gi] & ~clr_bits[gi]) | events[gi]);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flags_ff[gi] <= 8'h00;
				end else begin
					flags_ff[gi] <= nxt_flags[gi];
				end
			end
		end
	endgenerate

	assign nxt_irq = |((nxt_flags[0] & regs_ff[`REG_IDX_MASK1]) |
		(nxt_flags[1] & regs_ff[`REG_IDX_MASK2]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	// count restarts on any period write so the new period applies cleanly
	assign wake_enable = regs_ff[`REG_IDX_OPCTL1][`BIT_ENWT];

	wake_timer u_wake_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.enable   (wake_enable),
		.restart  (swres_ff || (wr_en && (idx == `REG_IDX_WTEXP ||
			idx == `REG_IDX_WTMHI || idx == `REG_IDX_WTMLO))),
		.exponent (regs_ff[`REG_IDX_WTEXP][4:0]),                 // R03
		.mantissa ({regs_ff[`REG_IDX_WTMHI],
			regs_ff[`REG_IDX_WTMLO]}),                              // R04
		.count    (wake_count),
		.expired  (wake_expired)
	);

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq     = irq_ff;

	assign cfg.operating_control_first  = regs_ff[`REG_IDX_OPCTL1];
	assign cfg.operating_control_second = regs_ff[`REG_IDX_OPCTL2]; // R02
	assign cfg.crystal_load_trim        = regs_ff[`REG_IDX_XTAL];
	assign cfg.host_clock_output        = regs_ff[`REG_IDX_CLKOUT];
	assign cfg.pin0_function_select     = regs_ff[`REG_IDX_PIN0];
	assign cfg.pin1_function_select     = regs_ff[`REG_IDX_PIN1];
	assign cfg.pin2_function_select     = regs_ff[`REG_IDX_PIN2];
	assign cfg.io_port_setup            = regs_ff[`REG_IDX_IOPORT];
	assign cfg.converter_setup          = regs_ff[`REG_IDX_ADCSET];
	assign cfg.sensor_amp_offset        = regs_ff[`REG_IDX_ADCOFFS];
	assign cfg.thermal_sensor_setup     = regs_ff[`REG_IDX_TSCTL];
	assign cfg.thermal_value_offset     = regs_ff[`REG_IDX_TVOFFS];
	assign cfg.duty_cycle_on_time       = regs_ff[`REG_IDX_LDC];    // R06
	assign cfg.battery_alarm_threshold  = regs_ff[`REG_IDX_LBDT];
endmodule

// file: radio_regs_defines.svh
`ifndef RADIO_REGS_DEFINES_SVH
`define RADIO_REGS_DEFINES_SVH

`define REG_COUNT          28
`define REG_IDX_TYPE       5'h00
`define REG_IDX_REV        5'h01
`define REG_IDX_STATE      5'h02
`define REG_IDX_FLAGS1     5'h03
`define REG_IDX_FLAGS2     5'h04
`define REG_IDX_MASK1      5'h05
`define REG_IDX_MASK2      5'h06
`define REG_IDX_OPCTL1     5'h07
`define REG_IDX_OPCTL2     5'h08
`define REG_IDX_XTAL       5'h09
`define REG_IDX_CLKOUT     5'h0a
`define REG_IDX_PIN0       5'h0b
`define REG_IDX_PIN1       5'h0c
`define REG_IDX_PIN2       5'h0d
`define REG_IDX_IOPORT     5'h0e
`define REG_IDX_ADCSET     5'h0f
`define REG_IDX_ADCOFFS    5'h10
`define REG_IDX_ADCVAL     5'h11
`define REG_IDX_TSCTL      5'h12
`define REG_IDX_TVOFFS     5'h13
`define REG_IDX_WTEXP      5'h14
`define REG_IDX_WTMHI      5'h15
`define REG_IDX_WTMLO      5'h16
`define REG_IDX_WTVHI      5'h17
`define REG_IDX_WTVLO      5'h18
`define REG_IDX_LDC        5'h19
`define REG_IDX_LBDT       5'h1a
`define REG_IDX_VBAT       5'h1b
`define REG_IDX_LAST       5'h1b

`define RST_MASK1          8'h00
`define RST_MASK2          8'h03
`define RST_OPCTL1         8'h01
`define RST_OPCTL2         8'h00
`define RST_XTAL           8'h7f
`define RST_CLKOUT         8'h06
`define RST_TSCTL          8'h20
`define RST_WTEXP          8'h03
`define RST_WTMHI          8'h00
`define RST_WTMLO          8'h01
`define RST_LDC            8'h00
`define RST_LBDT           8'h14
`define RST_ZERO           8'h00

`define WMASK_FULL         8'hff
`define WMASK_CLKOUT       8'h3f
`define WMASK_OPCTL1       8'h7f
`define WMASK_IOPORT       8'h7f
`define WMASK_ADCOFFS      8'h0f
`define WMASK_WTEXP        8'h1f
`define WMASK_LBDT         8'h1f
`define RMASK_STATE        8'hf3
`define RMASK_FIVE         8'h1f

`define BIT_SWRES          7
`define BIT_ENWT           5
`define BIT_IWUT           3
`define PADDR_IDX_HI       6
`define PADDR_IDX_LO       2
`define PADDR_TOP          7

`endif

// file: radio_regs_pkg.sv
package radio_regs_pkg;

	typedef enum logic {
		PH_IDLE   = 1'b0,
		PH_ACCESS = 1'b1
	} apb_phase_t;

	typedef struct packed {
		logic [7:0] dev_state;
		logic [7:0] events_first;
		logic [7:0] events_second;
		logic [7:0] adc_value;
		logic [4:0] battery_level;
	} radio_status_t;

	typedef struct packed {
		logic [7:0] operating_control_first;
		logic [7:0] operating_control_second;
		logic [7:0] crystal_load_trim;
		logic [7:0] host_clock_output;
		logic [7:0] pin0_function_select;
		logic [7:0] pin1_function_select;
		logic [7:0] pin2_function_select;
		logic [7:0] io_port_setup;
		logic [7:0] converter_setup;
		logic [7:0] sensor_amp_offset;
		logic [7:0] thermal_sensor_setup;
		logic [7:0] thermal_value_offset;
		logic [7:0] duty_cycle_on_time;
		logic [7:0] battery_alarm_threshold;
	} radio_cfg_t;

endpackage

// file: wake_timer.sv
`timescale 1ns/10ps
`include "radio_regs_defines.svh"

module wake_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        enable,
	input  wire logic        restart,
	input  wire logic [4:0]  exponent,
	input  wire logic [15:0] mantissa,
	output logic      [15:0] count,
	output logic             expired
);
	logic [31:0] prescale_ff;
	logic [15:0] count_ff;
	logic        expired_ff;
	logic [31:0] low_mask;
	logic        tick;
	logic        reach;

	// prescaler divides pclk by two to the power of the exponent
	assign low_mask = (32'h0000_0001 << exponent) - 32'h0000_0001;
	assign tick     = enable && ((prescale_ff & low_mask) == low_mask);
	assign reach    = tick && (count_ff >= mantissa);
	assign count    = count_ff;
	assign expired  = expired_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_ff <= 32'h0000_0000;
			count_ff    <= 16'h0000;
			expired_ff  <= 1'b0;
		end else begin
			prescale_ff <= (restart || !enable) ? 32'h0000_0000 :
				prescale_ff + 32'h0000_0001;
			count_ff    <= (restart || !enable || reach) ? 16'h0000 :
				(tick ? count_ff + 16'h0001 : count_ff);
			expired_ff  <= reach && !restart;
		end
	end
endmodule

// file: radio_control_register_bank_props.sv
`timescale 1ns/10ps
module radio_control_register_bank_props (
	input wire logic                          pclk,
	input wire logic                          presetn,
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [7:0]                    paddr,
	input wire logic [31:0]                   pwdata,
	input wire logic [31:0]                   prdata,
	input wire logic                          pready,
	input wire logic                          pslverr,
	input wire logic                          irq,
	input wire radio_regs_pkg::radio_status_t status,
	input wire radio_regs_pkg::radio_cfg_t    cfg
);
	import radio_regs_pkg::*;
	wire setup    = psel && !penable;
	wire wr_done  = psel && penable && pready && pwrite;
	wire bad_addr = paddr[7] || (paddr[6:2] > 5'h1b);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_next: assert property (setup |=> pready)
		else $error("ready missing after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_decode: assert property (setup |=> pslverr == $past(bad_addr))
		else $error("error flag wrong for address");
	chk_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 0)
		else $error("read data outside read access");
	chk_rdata_upper: assert property (prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	chk_ctl_reset: assert property ($rose(presetn) |->
		cfg.operating_control_first == 8'h01 &&
		cfg.operating_control_second == 8'h00)
		else $error("control bytes wrong after reset");
	chk_misc_reset: assert property ($rose(presetn) |->
		cfg.duty_cycle_on_time == 8'h00 && cfg.sensor_amp_offset == 8'h00 &&
		cfg.battery_alarm_threshold == 8'h14)
		else $error("config bytes wrong after reset");
	chk_reserved_zero: assert property (
		cfg.battery_alarm_threshold[7:5] == 3'h0 &&
		cfg.sensor_amp_offset[7:4] == 4'h0 && cfg.io_port_setup[7] == 1'b0)
		else $error("reserved config bit set");
	chk_cfg_cause: assert property (!$stable(cfg) |->
		$past(wr_done) || $past(wr_done, 2))
		else $error("config changed without a write");
endmodule

// file: host_apb_model.sv
`timescale 1ns/10ps
module host_apb_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// one transfer; gives up after 16 cycles so a hung slave cannot stall us
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q,
		output logic err, output logic ok);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// values read right after the edge are those that the edge sampled
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata[7:0];
		err = pslverr;
		ok = (pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// file: radio_control_register_bank_bench.sv
`timescale 1ns/10ps
module radio_control_register_bank_bench;
	import radio_regs_pkg::*;
	localparam logic [4:0] TYPE_ID = 5'h0a; // arbitrary value
	localparam logic [4:0] REV_ID  = 5'h01; // arbitrary value
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic          irq, err, ok;
	logic [7:0]    paddr, q, d;
	logic [31:0]   pwdata, prdata;
	logic [7:0]    mirror [0:31];
	radio_status_t status;
	radio_cfg_t    cfg;
	int            mismatches, tests_run, seed, n;

	radio_control_register_bank #(.TYPE_CODE(TYPE_ID), .REV_CODE(REV_ID))
		radio_control_register_bank_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .status(status), .cfg(cfg));
	host_apb_model host_apb_model_inst (.pclk(pclk), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	function automatic logic [7:0] rst_val(input logic [4:0] i);
		case (i)
			5'h06, 5'h14: return 8'h03;
			5'h07, 5'h16: return 8'h01;
			5'h09: return 8'h7f;
			5'h0a: return 8'h06;
			5'h12: return 8'h20;
			5'h1a: return 8'h14;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] wmask(input logic [4:0] i);
		case (i)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h04: return 8'h00;
			5'h11, 5'h17, 5'h18, 5'h1b: return 8'h00;
			5'h0a: return 8'h3f;
			5'h07, 5'h0e: return 8'h7f;
			5'h10: return 8'h0f;
			5'h14, 5'h1a: return 8'h1f;
			default: return (i > 5'h1b) ? 8'h00 : 8'hff;
		endcase
	endfunction
	function automatic logic [7:0] expect_rd(input logic [4:0] i);
		case (i)
			5'h00: return {3'h0, TYPE_ID};
			5'h01: return {3'h0, REV_ID};
			5'h02: return status.dev_state & 8'hf3;
			5'h11: return status.adc_value;
			5'h1b: return {3'h0, status.battery_level};
			default: return mirror[i];
		endcase
	endfunction
	function automatic logic [7:0] ba(input logic [4:0] i);
		return {1'b0, i, 2'b00};
	endfunction

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		host_apb_model_inst.xfer(w, a, v, q, err, ok);
		if (ok !== 1'b1) begin
			mismatches++;
			test_done();
		end
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 32; i++) mirror[i] = rst_val(5'(i));
	endtask
	task automatic sweep();
		for (int i = 0; i < 32; i++) begin
			if (i inside {3, 4, 23, 24}) continue;
			acc(1'b0, ba(5'(i)), 8'h00);
			check("read data", q, expect_rd(5'(i)));
			check("slave error", {7'h0, err}, {7'h0, i > 27});
		end
		acc(1'b0, 8'h84, 8'h00);
		check("high address error", {7'h0, err}, 8'h01);
	endtask
	task automatic scramble();
		status.dev_state <= 8'($random(seed));
		status.adc_value <= 8'($random(seed));
		status.battery_level <= 5'($random(seed));
		for (int i = 0; i < 32; i++) begin
			d = 8'($random(seed));
			// software reset and wake timer stay off in random traffic
			if (i == 7) d = d & 8'h5f;
			acc(1'b1, ba(5'(i)), d);
			if (wmask(5'(i)) != 8'h00) mirror[i] = d & wmask(5'(i));
		end
	endtask

	initial begin
		seed = 32'h23500852;
		presetn = 1'b0;
		status = '0;
		mismatches = 0;
		tests_run = 0;
		do_reset();
		sweep();
		repeat (2) begin
			scramble();
			sweep();
		end
		acc(1'b1, ba(5'h05), 8'h00);
		@(posedge pclk) status.events_first <= 8'h81;
		@(posedge pclk) status.events_first <= 8'h00;
		@(negedge pclk) check("irq masked", {7'h0, irq}, 8'h00);
		acc(1'b0, ba(5'h03), 8'h00);
		check("event flags", q, 8'h81);
		acc(1'b1, ba(5'h05), 8'h01);
		repeat (2) @(negedge pclk);
		check("irq unmasked", {7'h0, irq}, 8'h01);
		acc(1'b1, ba(5'h03), 8'h01);
		repeat (2) @(negedge pclk);
		check("irq cleared", {7'h0, irq}, 8'h00);
		acc(1'b0, ba(5'h03), 8'h00);
		check("flags after clear", q, 8'h80);
		acc(1'b1, ba(5'h14), 8'h00);
		acc(1'b1, ba(5'h15), 8'h00);
		acc(1'b1, ba(5'h16), 8'h03);
		acc(1'b1, ba(5'h06), 8'h08);
		acc(1'b1, ba(5'h07), 8'h21);
		n = 0;
		while (irq !== 1'b1 && n < 40) begin
			@(negedge pclk);
			n++;
		end
		check("wake irq", {7'h0, irq}, 8'h01);
		acc(1'b0, ba(5'h17), 8'h00);
		check("wake count high", q, 8'h00);
		acc(1'b1, ba(5'h07), 8'h01);
		acc(1'b1, ba(5'h04), 8'h08);
		acc(1'b0, ba(5'h04), 8'h00);
		check("wake flag cleared", q & 8'h08, 8'h00);
		acc(1'b1, ba(5'h07), 8'h80);
		for (int i = 0; i < 32; i++) mirror[i] = rst_val(5'(i));
		sweep();
		scramble();
		do_reset();
		sweep();
		test_done();
	end
endmodule

bind radio_control_register_bank radio_control_register_bank_props
	radio_control_register_bank_props_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq(irq), .status(status), .cfg(cfg));
